// ---- src/epis_pkg.sv ----
package epis_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL_SENSE  = 8'h00;
   localparam logic [7:0] OFS_CTRL_STATUS = 8'h04;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'h08;
   localparam logic [7:0] OFS_IRQ_FLAG    = 8'h0c;
   localparam logic [7:0] OFS_CPU_STATUS  = 8'h10;
   localparam logic [7:0] OFS_EVT_STATUS  = 8'h14;
   localparam logic [7:0] OFS_EVT_MASK    = 8'h18;
   localparam logic [7:0] OFS_SLEEP_CTRL  = 8'h1c;

   // ==========================================================
   // Field positions
   localparam int SENSE_A_LO_BIT   = 0;
   localparam int SENSE_B_LO_BIT   = 2;
   localparam int SENSE_C_EDGE_BIT = 6;
   localparam int PIN_C_BIT        = 5;
   localparam int PIN_A_BIT        = 6;
   localparam int PIN_B_BIT        = 7;
   localparam int GIE_BIT          = 7;
   localparam int SLEEP_GO_BIT     = 0;
   localparam int SLEEP_MODE_LO    = 1;
   localparam int SLEEP_STATE_BIT  = 4;
   localparam int EVT_WAKE_BIT     = 3;

   // ==========================================================
   // Reset values
   localparam logic [7:0] CTRL_SENSE_RST  = 8'h00;
   localparam logic [2:0] SLEEP_MODE_IDLE = 3'h0;
   localparam logic [3:0] EVT_MASK_RST    = 4'h0;

   // ==========================================================
   // Timing
   localparam int MCLK_MHZ       = 100;
   localparam int STARTUP_NS     = 4000;
   localparam int STARTUP_CYCLES = (STARTUP_NS * MCLK_MHZ + 999) / 1000;
   localparam int STARTUP_W      = 12;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      SENSE_LOW     = 2'b00,
      SENSE_ANY     = 2'b01,
      SENSE_FALLING = 2'b10,
      SENSE_RISING  = 2'b11
   } epis_sense_t;

   typedef enum logic [1:0] {
      ST_AWAKE   = 2'b00,
      ST_ASLEEP  = 2'b01,
      ST_SAMPLE1 = 2'b10,
      ST_STARTUP = 2'b11
   } epis_state_t;

   typedef struct packed {
      logic       read;
      logic       write;
      logic [7:0] address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } epis_bus_req_t;

endpackage

// ---- src/epis_sync2.sv ----
`timescale 1ns/1ps
module epis_sync2 #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         // Idle-high pins, no false edge after reset
         meta_q <= '1;
         q      <= '1;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule // epis_sync2

// ---- src/epis_sense.sv ----
`timescale 1ns/1ps
module epis_sense (
   input  wire logic                 mclk,
   input  wire logic                 reset_n,
   input  wire logic                 pin_s,
   input  wire epis_pkg::epis_sense_t mode,
   input  wire logic                 io_run,
   output logic                      edge_hit,
   output logic                      level_low
);
   logic prev_q;
   logic prev_d;
   logic rise;
   logic fall;

   // sample held while io clock halted
   assign prev_d = io_run ? pin_s : prev_q;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         prev_q <= 1'b1;
      end else begin
         prev_q <= prev_d;
      end
   end

   assign rise = pin_s & ~prev_q;
   assign fall = ~pin_s & prev_q;

   assign edge_hit = io_run &
      (((mode == epis_pkg::SENSE_ANY) & (rise | fall)) |
       ((mode == epis_pkg::SENSE_FALLING) & fall) |
       ((mode == epis_pkg::SENSE_RISING) & rise));

   assign level_low = (mode == epis_pkg::SENSE_LOW) & ~pin_s;
endmodule // epis_sense

// ---- src/epis_top.sv ----
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Requests are raised from the pin level even when it is an output.
// - Third input is edge-only; first two have level and edge modes.
// - Low-level mode keeps the request asserted while the pin is low.
// - Edge detection on first two inputs runs only while io clock runs.
// - Low level and third input edge still detected when io clock halts.
// - Io clock halted in every sleep mode except idle.
// - Level wake from power-down needs two watchdog-clock samples low.
// - Wake after both samples and start-up time, whether or not the level is still held.
// - Level gone by end of start-up: wake, but no level request.
// - A request is taken only with global enable and its mask bit set.
// - Pin is registered first; edges compare registered samples.
// - Pulses longer than one clock period give an edge request.
// - Second input sense bits 3:2: low, any, falling, rising.
// - First input sense bits 1:0 with the same encodings.
// - Third input sense bit: 0 falling, 1 rising; change may trigger.
// - Edge sets flag; cleared by handler or write one; clear in level.
module epis_top (
   input  wire logic        mclk,
   input  wire logic        reset_n,
   // Avalon-MM slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Pins
   input  wire logic        ext_irq_in_a,
   input  wire logic        ext_irq_in_b,
   input  wire logic        ext_irq_in_c,
   // Watchdog oscillator tick
   input  wire logic        wdt_tick,
   // Handler entry
   input  wire logic        irq_ack,
   input  wire logic [1:0]  irq_ack_sel,
   // Outputs
   output logic      [2:0]  irq_req,
   output logic             io_clk_run,
   output logic             sleeping,
   output logic             wake,
   output logic             irq
);

   // ==========================================================
   // State
   epis_pkg::epis_bus_req_t bus;
   epis_pkg::epis_state_t   state_q;
   epis_pkg::epis_state_t   state_d;
   logic [7:0]  sense_ctl_q;
   logic        sense_c_q;
   logic [2:0]  mask_q;
   logic [2:0]  flag_q;
   logic [2:0]  flag_d;
   logic        gie_q;
   logic [3:0]  evt_q;
   logic [3:0]  evt_d;
   logic [3:0]  emask_q;
   logic [2:0]  sleep_mode_q;

   localparam int STARTUP_W_L = epis_pkg::STARTUP_W;
   localparam logic [STARTUP_W_L-1:0] STARTUP_LAST =
      STARTUP_W_L'(epis_pkg::STARTUP_CYCLES - 1);

   logic [STARTUP_W_L-1:0] start_cnt_q;
   logic [STARTUP_W_L-1:0] start_cnt_d;
   logic        wait_q;
   logic [31:0] rdata_d;
   logic [2:0]  req_d;
   logic        wake_d;
   logic        io_run_d;
   logic        cond_c_q;

   assign bus.read       = avs_read;
   assign bus.write      = avs_write;
   assign bus.address    = avs_address;
   assign bus.byteenable = avs_byteenable;
   assign bus.writedata  = avs_writedata;

   // ==========================================================
   // Pin synchronisers
   logic [2:0] pins_s;

   epis_sync2 #(
      .W (3)
   ) u_sync (
      .mclk    (mclk),
      .reset_n (reset_n),
      .d       ({ext_irq_in_c, ext_irq_in_b, ext_irq_in_a}),
      .q       (pins_s)
   );

   // ==========================================================
   // Sense units for first two inputs
   epis_pkg::epis_sense_t mode_a;
   epis_pkg::epis_sense_t mode_b;
   logic hit_a;
   logic hit_b;
   logic low_a;
   logic low_b;
   logic io_run;

   assign mode_a = epis_pkg::epis_sense_t'(
      sense_ctl_q[epis_pkg::SENSE_A_LO_BIT +: 2]);
   assign mode_b = epis_pkg::epis_sense_t'(
      sense_ctl_q[epis_pkg::SENSE_B_LO_BIT +: 2]);

   // io clock runs awake or in idle
   assign io_run_d = (state_d == epis_pkg::ST_AWAKE) |
                     (sleep_mode_q == epis_pkg::SLEEP_MODE_IDLE);
   assign io_run   = io_clk_run;

   epis_sense u_sense_a (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .pin_s     (pins_s[0]),
      .mode      (mode_a),
      .io_run    (io_run),
      .edge_hit  (hit_a),
      .level_low (low_a)
   );

   epis_sense u_sense_b (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .pin_s     (pins_s[1]),
      .mode      (mode_b),
      .io_run    (io_run),
      .edge_hit  (hit_b),
      .level_low (low_b)
   );

   // ==========================================================
   // Third input, edge only, not gated by io clock
   logic cond_c;
   logic hit_c;

   // polarity select; flipping it may trigger
   assign cond_c = sense_c_q ? pins_s[2] : ~pins_s[2];
   assign hit_c  = cond_c & ~cond_c_q;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cond_c_q <= 1'b1;
      end else begin
         cond_c_q <= cond_c;
      end
   end

   // ==========================================================
   // Bus decode
   logic bus_go;
   logic wr_go;
   logic rd_go;
   logic be0;
   logic sel_sense;
   logic sel_status;
   logic sel_mask;
   logic sel_flag;
   logic sel_cpu;
   logic sel_evt;
   logic sel_emask;
   logic sel_sleep;
   logic [7:0] wb;

   assign bus_go     = (bus.read | bus.write) & ~wait_q;
   assign be0        = bus.byteenable[0];
   assign wr_go      = bus_go & bus.write & be0;
   assign rd_go      = bus_go & bus.read;
   assign wb         = bus.writedata[7:0];
   assign sel_sense  = bus.address == epis_pkg::OFS_CTRL_SENSE;
   assign sel_status = bus.address == epis_pkg::OFS_CTRL_STATUS;
   assign sel_mask   = bus.address == epis_pkg::OFS_IRQ_MASK;
   assign sel_flag   = bus.address == epis_pkg::OFS_IRQ_FLAG;
   assign sel_cpu    = bus.address == epis_pkg::OFS_CPU_STATUS;
   assign sel_evt    = bus.address == epis_pkg::OFS_EVT_STATUS;
   assign sel_emask  = bus.address == epis_pkg::OFS_EVT_MASK;
   assign sel_sleep  = bus.address == epis_pkg::OFS_SLEEP_CTRL;

   // Pin-ordered triple into register bit layout
   function automatic logic [7:0] pack3(input logic [2:0] v);
      logic [7:0] r;
      r = 8'h00;
      r[epis_pkg::PIN_A_BIT] = v[0];
      r[epis_pkg::PIN_B_BIT] = v[1];
      r[epis_pkg::PIN_C_BIT] = v[2];
      return r;
   endfunction

   function automatic logic [2:0] unpack3(input logic [7:0] r);
      return {r[epis_pkg::PIN_C_BIT], r[epis_pkg::PIN_B_BIT],
              r[epis_pkg::PIN_A_BIT]};
   endfunction

   logic [7:0] sleep_rd;
   assign sleep_rd = {3'h0, (state_q != epis_pkg::ST_AWAKE),
                      sleep_mode_q, 1'b0};

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (sel_sense) begin
         rdata_d[7:0] = sense_ctl_q;
      end else if (sel_status) begin
         rdata_d[epis_pkg::SENSE_C_EDGE_BIT] = sense_c_q;
      end else if (sel_mask) begin
         rdata_d[7:0] = pack3(mask_q);
      end else if (sel_flag) begin
         rdata_d[7:0] = pack3(flag_q);
      end else if (sel_cpu) begin
         rdata_d[epis_pkg::GIE_BIT] = gie_q;
      end else if (sel_evt) begin
         rdata_d[3:0] = evt_q;
      end else if (sel_emask) begin
         rdata_d[3:0] = emask_q;
      end else if (sel_sleep) begin
         rdata_d[7:0] = sleep_rd;
      end
   end

   // ==========================================================
   // Flags
   logic [2:0] lvl_mode;
   logic [2:0] flag_set;
   logic [2:0] flag_clr;
   logic [2:0] ack_vec;
   logic [2:0] w1c_vec;

   assign lvl_mode = {1'b0, mode_b == epis_pkg::SENSE_LOW,
                      mode_a == epis_pkg::SENSE_LOW};
   // pin level used regardless of direction
   assign flag_set = {hit_c, hit_b, hit_a} & ~lvl_mode;
   assign ack_vec  = irq_ack ? (3'h1 << irq_ack_sel) : 3'h0;
   assign w1c_vec  = (wr_go & sel_flag) ? unpack3(wb) : 3'h0;
   assign flag_clr = ack_vec | w1c_vec | lvl_mode;
   assign flag_d   = flag_set | (flag_q & ~flag_clr);

   // ==========================================================
   // Requests
   logic [2:0] pending;

   // level request follows pin; gone level gives none
   assign pending = {flag_q[2],
                     lvl_mode[1] ? low_b : flag_q[1],
                     lvl_mode[0] ? low_a : flag_q[0]};
   assign req_d = gie_q ? (pending & mask_q) : 3'h0;

   // ==========================================================
   // Sleep and wake sequencing
   logic level_wake;
   logic sleep_go;
   logic in_idle;
   logic start_done;

   assign level_wake = |({low_b, low_a} & mask_q[1:0]);
   assign sleep_go   = wr_go & sel_sleep & wb[epis_pkg::SLEEP_GO_BIT];
   assign in_idle    = sleep_mode_q == epis_pkg::SLEEP_MODE_IDLE;
   assign start_done = start_cnt_q == STARTUP_LAST;

   always_comb begin
      state_d     = state_q;
      start_cnt_d = '0;
      wake_d      = 1'b0;
      unique case (state_q)
         epis_pkg::ST_AWAKE: begin
            if (sleep_go) begin
               state_d = epis_pkg::ST_ASLEEP;
            end
         end
         epis_pkg::ST_ASLEEP: begin
            // clockless sources wake from any mode
            if ((in_idle & (|(pending & mask_q))) |
                (flag_q[2] & mask_q[2])) begin
               state_d = epis_pkg::ST_STARTUP;
            end else if (level_wake & wdt_tick) begin
               state_d = epis_pkg::ST_SAMPLE1;
            end
         end
         epis_pkg::ST_SAMPLE1: begin
            if (wdt_tick) begin
               state_d = level_wake ? epis_pkg::ST_STARTUP
                                    : epis_pkg::ST_ASLEEP;
            end
         end
         epis_pkg::ST_STARTUP: begin
            start_cnt_d = start_cnt_q + 1'b1;
            if (start_done) begin
               state_d = epis_pkg::ST_AWAKE;
               wake_d  = 1'b1;
            end
         end
      endcase
   end

   // ==========================================================
   // Event status, read clears, set wins
   logic [3:0] evt_set;
   logic [3:0] evt_clr;

   assign evt_set = {wake_d, flag_set & ~flag_q};
   assign evt_clr = (rd_go & sel_evt) ? evt_q : 4'h0;
   assign evt_d   = evt_set | (evt_q & ~evt_clr);

   // ==========================================================
   // Registers
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wait_q       <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         wait_q       <= ~((bus.read | bus.write) & wait_q);
         if ((bus.read | bus.write) & wait_q) begin
            avs_readdata <= rdata_d;
         end
      end
   end

   assign avs_waitrequest = wait_q;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sense_ctl_q  <= epis_pkg::CTRL_SENSE_RST;
         sense_c_q    <= 1'b0;
         mask_q       <= 3'h0;
         gie_q        <= 1'b0;
         emask_q      <= epis_pkg::EVT_MASK_RST;
         sleep_mode_q <= epis_pkg::SLEEP_MODE_IDLE;
      end else if (wr_go) begin
         if (sel_sense) sense_ctl_q <= wb;
         if (sel_status) sense_c_q <= wb[epis_pkg::SENSE_C_EDGE_BIT];
         if (sel_mask) mask_q <= unpack3(wb);
         if (sel_cpu) gie_q <= wb[epis_pkg::GIE_BIT];
         if (sel_emask) emask_q <= wb[3:0];
         if (sel_sleep) sleep_mode_q <= wb[epis_pkg::SLEEP_MODE_LO +: 3];
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         flag_q      <= 3'h0;
         evt_q       <= 4'h0;
         state_q     <= epis_pkg::ST_AWAKE;
         start_cnt_q <= '0;
      end else begin
         flag_q      <= flag_d;
         evt_q       <= evt_d;
         state_q     <= state_d;
         start_cnt_q <= start_cnt_d;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         irq_req    <= 3'h0;
         io_clk_run <= 1'b1;
         sleeping   <= 1'b0;
         wake       <= 1'b0;
         irq        <= 1'b0;
      end else begin
         irq_req    <= req_d;
         io_clk_run <= io_run_d;
         sleeping   <= state_d != epis_pkg::ST_AWAKE;
         wake       <= wake_d;
         irq        <= |(evt_d & emask_q);
      end
   end

endmodule // epis_top

// ---- verif/epis_assertions.sv ----
`timescale 1ns/1ps
module epis_assertions (
   input wire logic        mclk,
   input wire logic        reset_n,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        ext_irq_in_c,
   input wire logic        irq_ack,
   input wire logic [1:0]  irq_ack_sel,
   input wire logic [2:0]  irq_req,
   input wire logic        io_clk_run,
   input wire logic        sleeping,
   input wire logic        wake
);
   // ==========================================================
   // Cycles since third pin moved or a write
   logic [3:0] quiet_q;
   logic [3:0] quiet_d;
   logic       c_last_q;

   assign quiet_d = (avs_write || ext_irq_in_c != c_last_q) ? 4'h0
                  : (quiet_q == 4'hf) ? quiet_q : quiet_q + 4'h1;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         quiet_q  <= 4'h0;
         c_last_q <= 1'b1;
      end else begin
         quiet_q  <= quiet_d;
         c_last_q <= ext_irq_in_c;
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);

   // ==========================================================
   // Properties
   property p_wait_ans;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait_ans: assert property (p_wait_ans)
      else $error("access not answered next cycle");
   property p_wait_one;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("waitrequest low too long");
   property p_wait_idle;
      !avs_read && !avs_write |=> avs_waitrequest;
   endproperty
   a_wait_idle: assert property (p_wait_idle)
      else $error("waitrequest low without access");
   property p_rd_hold;
      !((avs_read || avs_write) && avs_waitrequest) |=> $stable(avs_readdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("readdata moved without access");
   property p_rd_upper;
      avs_readdata[31:8] == 24'h0;
   endproperty
   a_rd_upper: assert property (p_rd_upper)
      else $error("readdata upper bits set");
   property p_run;
      !sleeping |-> io_clk_run;
   endproperty
   a_run: assert property (p_run)
      else $error("io clock halted while awake");
   property p_wake;
      wake |=> !wake && !sleeping;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake pulse not single or still asleep");
   property p_ack_c;
      irq_ack && irq_ack_sel == 2'h2 && quiet_q > 4'h4 |=> ##1 !irq_req[2];
   endproperty
   a_ack_c: assert property (p_ack_c)
      else $error("third request not cleared by ack");
   property p_rose_c;
      $rose(irq_req[2]) |-> quiet_q < 4'h8;
   endproperty
   a_rose_c: assert property (p_rose_c)
      else $error("third request without cause");
endmodule // epis_assertions

bind epis_top epis_assertions epis_assertions_i (.mclk, .reset_n,
   .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .ext_irq_in_c,
   .irq_ack, .irq_ack_sel, .irq_req, .io_clk_run, .sleeping, .wake);

// ---- verif/epis_pin_src.sv ----
`timescale 1ns/1ps
module epis_pin_src #(
   parameter int WDT_CYC = 100
) (
   input  wire logic       mclk,
   input  wire logic [2:0] lvl,
   output logic            ext_irq_in_a,
   output logic            ext_irq_in_b,
   output logic            ext_irq_in_c,
   output logic            wdt_tick
);
   logic [2:0] pin_q  = 3'h7;
   logic       tick_q = 1'b0;
   int         cnt_q  = 0;

   assign ext_irq_in_a = pin_q[0];
   assign ext_irq_in_b = pin_q[1];
   assign ext_irq_in_c = pin_q[2];
   assign wdt_tick     = tick_q;

   always @(posedge mclk) begin
      pin_q  <= lvl;
      cnt_q  <= (cnt_q == WDT_CYC - 1) ? 0 : cnt_q + 1;
      tick_q <= (cnt_q == WDT_CYC - 1);
   end
endmodule // epis_pin_src

// ---- verif/tb_epis_top.sv ----
`timescale 1ns/1ps
module tb_epis_top;
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] e;
      logic [31:0] m;
   } epis_note_t;

   logic                    mclk, reset_n, wdt_tick, irq_ack;
   logic                    ext_irq_in_a, ext_irq_in_b, ext_irq_in_c;
   logic                    avs_waitrequest, io_clk_run, sleeping, wake, irq;
   logic [31:0]             avs_readdata, d, f;
   logic [1:0]              irq_ack_sel;
   logic [2:0]              irq_req, lvl;
   epis_pkg::epis_bus_req_t req;
   epis_note_t              nt;
   epis_note_t              q[$];
   int                      fail_count, cmp_count, seed, n;

   epis_pin_src epis_pin_src_i (.mclk, .lvl, .ext_irq_in_a, .ext_irq_in_b,
      .ext_irq_in_c, .wdt_tick);
   epis_top epis_top_i (.mclk, .reset_n, .avs_address(req.address),
      .avs_read(req.read), .avs_write(req.write), .avs_writedata(req.writedata),
      .avs_byteenable(req.byteenable), .avs_readdata, .avs_waitrequest,
      .ext_irq_in_a, .ext_irq_in_b, .ext_irq_in_c, .wdt_tick, .irq_ack,
      .irq_ack_sel, .irq_req, .io_clk_run, .sleeping, .wake, .irq);

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // ==========================================================
   // Tasks
   task automatic test_done;
      if (fail_count == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string s, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask

   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [31:0] dw, input logic [3:0] be);
      int k;
      k = 0;
      @(posedge mclk);
      req <= '{read: !w, write: w, address: a, byteenable: be, writedata: dw};
      do begin
         @(posedge mclk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 64);
      req.read <= 1'b0;
      req.write <= 1'b0;
      if (k >= 64) begin
         fail_count++;
         test_done();
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m);
      q.push_back('{a: a, e: e, m: m});
      acc(1'b0, a, 32'h0, 4'hf);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      acc(1'b1, a, {24'h0, v}, 4'h1);
   endtask

   task automatic cyc(input int c);
      repeat (c) @(posedge mclk);
   endtask

   task automatic ack(input logic [1:0] s);
      @(posedge mclk);
      irq_ack <= 1'b1;
      irq_ack_sel <= s;
      @(posedge mclk);
      irq_ack <= 1'b0;
   endtask

   task automatic wait_wake;
      n = 0;
      while (wake !== 1'b1 && n < 2000) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 2000) begin
         fail_count++;
         test_done();
      end
   endtask

   // ==========================================================
   // Read data checker
   always @(posedge mclk) begin
      if (reset_n === 1'b1 && req.read === 1'b1 && avs_waitrequest === 1'b0) begin
         nt = q.pop_front();
         chk($sformatf("reg %h", nt.a), nt.e & nt.m, avs_readdata & nt.m);
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      seed = 82;
      fail_count = 0;
      cmp_count = 0;
      reset_n = 1'b0;
      req = '0;
      lvl = 3'h7;
      irq_ack = 1'b0;
      irq_ack_sel = 2'h0;
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
      rd(epis_pkg::OFS_CTRL_SENSE, 32'h0, 32'hffffffff);
      rd(epis_pkg::OFS_EVT_MASK, 32'h0, 32'hf);
      rd(8'h20, 32'h0, 32'hffffffff);
      d = $random(seed);
      wr(epis_pkg::OFS_CTRL_SENSE, d[7:0]);
      acc(1'b1, epis_pkg::OFS_CTRL_SENSE, ~d, 4'he);
      rd(epis_pkg::OFS_CTRL_SENSE, {24'h0, d[7:0]}, 32'hffffffff);
      wr(epis_pkg::OFS_CPU_STATUS, 8'h80);
      wr(epis_pkg::OFS_IRQ_MASK, 8'he0);
      for (int e = 0; e < 2; e++) begin
         wr(epis_pkg::OFS_CTRL_STATUS, 8'(e << epis_pkg::SENSE_C_EDGE_BIT));
         lvl[2] <= !e;
         cyc(6);
         wr(epis_pkg::OFS_IRQ_FLAG, 8'he0);
         lvl[2] <= e[0];
         cyc(8);
         rd(epis_pkg::OFS_IRQ_FLAG, 32'h20, 32'h20);
         chk("irq_req_c", 32'h1, 32'(irq_req[2]));
         ack(2'h2);
         cyc(3);
         chk("irq_req_c", 32'h0, 32'(irq_req[2]));
      end
      for (int p = 0; p < 2; p++) begin
         for (int m = 0; m < 4; m++) begin
            f = p ? 32'h80 : 32'h40;
            wr(epis_pkg::OFS_CTRL_SENSE, 8'(m << (2 * p)));
            cyc(4);
            wr(epis_pkg::OFS_IRQ_FLAG, 8'he0);
            lvl[p] <= 1'b0;
            cyc(6);
            if (m == 0) chk("irq_req_lvl", 32'h1, 32'(irq_req[p]));
            lvl[p] <= 1'b1;
            cyc(8);
            rd(epis_pkg::OFS_IRQ_FLAG, m ? f : 32'h0, f);
            chk("irq_req_ab", m ? 32'h1 : 32'h0, 32'(irq_req[p]));
            ack(2'(p));
            cyc(3);
            chk("irq_req_ab", 32'h0, 32'(irq_req[p]));
         end
      end
      wr(epis_pkg::OFS_CTRL_SENSE, 8'h02);
      wr(epis_pkg::OFS_CPU_STATUS, 8'h00);
      wr(epis_pkg::OFS_IRQ_FLAG, 8'he0);
      lvl[0] <= 1'b0;
      cyc(4);
      lvl[0] <= 1'b1;
      cyc(8);
      chk("irq_req_a", 32'h0, 32'(irq_req[0]));
      rd(epis_pkg::OFS_IRQ_FLAG, 32'h40, 32'h40);
      wr(epis_pkg::OFS_CPU_STATUS, 8'h80);
      cyc(3);
      chk("irq_req_a", 32'h1, 32'(irq_req[0]));
      chk("irq", 32'h0, 32'(irq));
      wr(epis_pkg::OFS_EVT_MASK, 8'h01);
      cyc(2);
      chk("irq", 32'h1, 32'(irq));
      rd(epis_pkg::OFS_EVT_STATUS, 32'h1, 32'h1);
      cyc(2);
      chk("irq", 32'h0, 32'(irq));
      ack(2'h0);
      wr(epis_pkg::OFS_CTRL_SENSE, 8'h08);
      wr(epis_pkg::OFS_IRQ_FLAG, 8'he0);
      wr(epis_pkg::OFS_SLEEP_CTRL, 8'h05);
      cyc(2);
      chk("io_clk_run", 32'h0, 32'(io_clk_run));
      rd(epis_pkg::OFS_SLEEP_CTRL, 32'h10, 32'h10);
      lvl[1] <= 1'b0;
      cyc(4);
      lvl[1] <= 1'b1;
      cyc(4);
      lvl[0] <= 1'b0;
      wait_wake();
      chk("wake_gap", 32'h1, 32'(n >= epis_pkg::STARTUP_CYCLES
          && n <= epis_pkg::STARTUP_CYCLES + 220));
      cyc(2);
      chk("sleeping", 32'h0, 32'(sleeping));
      chk("irq_req_a", 32'h1, 32'(irq_req[0]));
      rd(epis_pkg::OFS_IRQ_FLAG, 32'h0, 32'h80);
      lvl[0] <= 1'b1;
      cyc(6);
      wr(epis_pkg::OFS_SLEEP_CTRL, 8'h05);
      lvl[0] <= 1'b0;
      cyc(250);
      lvl[0] <= 1'b1;
      wait_wake();
      cyc(2);
      chk("irq_req_a", 32'h0, 32'(irq_req[0]));
      wr(epis_pkg::OFS_SLEEP_CTRL, 8'h01);
      cyc(2);
      chk("io_clk_run", 32'h1, 32'(io_clk_run));
      lvl[2] <= 1'b0;
      cyc(4);
      lvl[2] <= 1'b1;
      wait_wake();
      cyc(2);
      chk("sleeping", 32'h0, 32'(sleeping));
      ack(2'h2);
      test_done();
   end
endmodule // tb_epis_top
